// File: verilog/adcw_top.v
// two-wire read-only slave, sar sequencer and power control of the converter
`timescale 1ns/10ps
`include "adcw_map.vh"
// Notes on behaviour
// (RL1) power up in fast/standard timing
// (RL2) fastest rates need high-speed mode
// (RL3) master code 00001xxx, low bits ignored
// (RL4) no-ack master code, then enter high-speed
// (RL5) master follows with repeated start, address
// (RL6) stop returns to fast/standard timing
// (RL7) matching address acked, conversion begins
// (RL8) direction bit only controls power-down
// (RL9) stretch scl low until result ready
// (RL10) msb byte bits 13-6, then rest
// (RL11) master ack keeps conversions coming
// (RL12) master no-ack ends transmission, frees bus
// (RL13) power-on reset leaves device shut down
// (RL14) address powers up, conversion end powers down
// (RL15) internal reference stays on between conversions
// (RL16) external mode ignores direction bit
// (RL17) armed shutdown acts on master no-ack
// (RL18) reference wakes at 9th falling edge
// (RL19) master waits 12 ms for reference
// (RL20) straight binary 14-bit result
// (RL21) address 011 plus four select pins
// (RL22) nine scl cycles per byte
// (RL23) track two scl cycles before conversion
// (RL24) 4 MHz clock steps the sar
// (RL25) foreign address ignored until next start
module adcw_top #(
  parameter CONV_DIV = `ADCW_CONV_DIV,
  parameter FIFO_DEPTH = `ADCW_FIFO_DEPTH
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // two-wire bus, open drain
  input wire scl_in,
  output wire scl_out,
  output wire scl_oe,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe,
  // straps
  input wire [3:0] address_select_pins,
  input wire reference_adjust_pin,
  // analog front end
  input wire cmp_in,
  output wire [`ADCW_WORD_W-1:0] dac_code,
  output wire track,
  // status
  output wire hs_mode,
  output wire conv_pwr,
  output wire ref_pwr,
  output wire conv_busy
);
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_ACK = 3'h2;
  localparam [2:0] ST_HSNACK = 3'h3;
  localparam [2:0] ST_CONV = 3'h4;
  localparam [2:0] ST_TX = 3'h5;
  localparam [2:0] ST_MACK = 3'h6;
  localparam [1:0] SR_IDLE = 2'h0;
  localparam [1:0] SR_RUN = 2'h1;
  localparam [1:0] SR_PUSH = 2'h2;
  localparam integer DIV_LAST_I = CONV_DIV - 1;
  localparam [7:0] DIV_LAST = DIV_LAST_I[7:0];

  // input synchronisers
  reg scl_s1_ff, scl_s2_ff, scl_d_ff, sda_s1_ff, sda_s2_ff, sda_d_ff, radj_s1_ff, radj_s2_ff;
  reg [3:0] asel_s1_ff, asel_s2_ff;
  // bus side state
  reg [2:0] st_ff;
  reg [3:0] cnt_ff;
  reg [7:0] rx_ff, tx_ff, lsb_byte_ff;
  reg byte_sel_ff, mack_ff, scl_oe_ff, sda_oe_ff, hs_ff, track_ff;
  reg conv_start_ff, pop_ff, flush_ff, shut_arm_ff, ref_pwr_ff;
  // sar state
  reg [1:0] sr_ff;
  reg [7:0] div_ff;
  reg [3:0] bit_ff;
  reg [`ADCW_WORD_W-1:0] dac_ff;
  reg conv_pwr_ff, busy_ff;
  wire scl_rise, scl_fall, start_cond, stop_cond, conv_tick;
  wire fifo_in_ready, fifo_out_valid;
  wire [`ADCW_WORD_W-1:0] fifo_out_data;

  function addr_match;
    input [7:0] b;
    input [3:0] sel;
    begin
      addr_match = (b[7:1] == {`ADCW_ADDR_FIXED, sel}); // [RL21]
    end
  endfunction

  assign scl_rise = scl_s2_ff & ~scl_d_ff;
  assign scl_fall = ~scl_s2_ff & scl_d_ff;
  assign start_cond = scl_s2_ff & scl_d_ff & ~sda_s2_ff & sda_d_ff;
  assign stop_cond = scl_s2_ff & scl_d_ff & sda_s2_ff & ~sda_d_ff;
  assign conv_tick = (div_ff == DIV_LAST);

  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = scl_oe_ff;
  assign sda_oe = sda_oe_ff;
  assign hs_mode = hs_ff; // [RL2]
  assign track = track_ff;
  assign conv_pwr = conv_pwr_ff;
  assign ref_pwr = ref_pwr_ff;
  assign conv_busy = busy_ff;
  assign dac_code = dac_ff;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // bus lines reset to their idle high level, so release shows no false edge
      {scl_s1_ff, scl_s2_ff, scl_d_ff} <= 3'h7;
      {sda_s1_ff, sda_s2_ff, sda_d_ff} <= 3'h7;
      {asel_s1_ff, asel_s2_ff} <= 8'h00;
      {radj_s1_ff, radj_s2_ff} <= 2'h0;
    end else begin
      {scl_s1_ff, scl_s2_ff, scl_d_ff} <= {scl_in, scl_s1_ff, scl_s2_ff};
      {sda_s1_ff, sda_s2_ff, sda_d_ff} <= {sda_in, sda_s1_ff, sda_s2_ff};
      {asel_s1_ff, asel_s2_ff} <= {address_select_pins, asel_s1_ff};
      {radj_s1_ff, radj_s2_ff} <= {reference_adjust_pin, radj_s1_ff};
    end
  end

  // bus side: bytes are eight data bits plus one acknowledge clock [RL22]
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= ST_IDLE;
      cnt_ff <= 4'h0;
      {rx_ff, tx_ff, lsb_byte_ff} <= 24'h000000;
      {byte_sel_ff, mack_ff, scl_oe_ff, sda_oe_ff} <= 4'h0;
      hs_ff <= 1'b0; // [RL1]
      {track_ff, conv_start_ff, pop_ff, flush_ff, shut_arm_ff} <= 5'h00;
      ref_pwr_ff <= 1'b0; // [RL13]
    end else begin
      conv_start_ff <= 1'b0;
      pop_ff <= 1'b0;
      flush_ff <= 1'b0;
      if (radj_s2_ff) begin
        ref_pwr_ff <= 1'b0;
      end
      if (stop_cond) begin
        st_ff <= ST_IDLE;
        hs_ff <= 1'b0; // [RL6]
        sda_oe_ff <= 1'b0;
        scl_oe_ff <= 1'b0;
        track_ff <= 1'b0;
        flush_ff <= 1'b1;
      end else if (start_cond) begin
        // also the repeated start that opens high-speed traffic [RL5]
        st_ff <= ST_ADDR;
        cnt_ff <= 4'h0;
        sda_oe_ff <= 1'b0;
        track_ff <= 1'b0;
      end else begin
        case (st_ff)
          ST_IDLE: begin
            sda_oe_ff <= 1'b0; // [RL25]
          end
          ST_ADDR: begin
            if (scl_rise) begin
              rx_ff <= {rx_ff[6:0], sda_s2_ff};
              cnt_ff <= cnt_ff + 4'h1;
              if (cnt_ff == `ADCW_TRACK_BIT - 4'h1) begin
                track_ff <= 1'b1; // [RL23]
              end
            end else if (scl_fall && cnt_ff == `ADCW_BYTE_BITS) begin
              if (rx_ff[7:3] == `ADCW_HS_CODE) begin
                st_ff <= ST_HSNACK; // [RL3]
                track_ff <= 1'b0;
              end else if (addr_match(rx_ff, asel_s2_ff)) begin
                st_ff <= ST_ACK;
                sda_oe_ff <= 1'b1; // [RL7]
              end else begin
                st_ff <= ST_IDLE; // [RL25]
                track_ff <= 1'b0;
              end
            end
          end
          ST_HSNACK: begin
            // sda stays released through the acknowledge clock
            if (scl_fall) begin
              hs_ff <= 1'b1; // [RL4]
              st_ff <= ST_IDLE;
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              sda_oe_ff <= 1'b0;
              scl_oe_ff <= 1'b1; // [RL9]
              track_ff <= 1'b0;
              conv_start_ff <= 1'b1;
              st_ff <= ST_CONV;
              // direction bit is never a read/write select [RL8]
              shut_arm_ff <= ~rx_ff[0] & ~radj_s2_ff; // [RL16]
              if (!radj_s2_ff) begin
                ref_pwr_ff <= 1'b1; // [RL18]
              end
            end
          end
          ST_CONV: begin
            if (fifo_out_valid && !pop_ff) begin
              pop_ff <= 1'b1;
              tx_ff <= fifo_out_data[15:8]; // [RL10]
              lsb_byte_ff <= fifo_out_data[7:0];
              sda_oe_ff <= ~fifo_out_data[15];
              byte_sel_ff <= 1'b0;
              cnt_ff <= 4'h1;
              scl_oe_ff <= 1'b0; // [RL9]
              st_ff <= ST_TX;
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (cnt_ff == `ADCW_BYTE_BITS) begin
                sda_oe_ff <= 1'b0;
                st_ff <= ST_MACK;
                if (byte_sel_ff) begin
                  track_ff <= 1'b1; // [RL23]
                end
              end else begin
                tx_ff <= {tx_ff[6:0], 1'b0};
                sda_oe_ff <= ~tx_ff[6];
                cnt_ff <= cnt_ff + 4'h1;
                if (byte_sel_ff && cnt_ff == `ADCW_TRACK_BIT) begin
                  track_ff <= 1'b1; // [RL23]
                end
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              mack_ff <= ~sda_s2_ff;
            end else if (scl_fall) begin
              if (mack_ff && !byte_sel_ff) begin
                tx_ff <= lsb_byte_ff; // [RL10]
                sda_oe_ff <= ~lsb_byte_ff[7];
                byte_sel_ff <= 1'b1;
                cnt_ff <= 4'h1;
                st_ff <= ST_TX;
              end else if (mack_ff) begin
                scl_oe_ff <= 1'b1; // [RL11]
                track_ff <= 1'b0;
                conv_start_ff <= 1'b1;
                st_ff <= ST_CONV;
              end else begin
                st_ff <= ST_IDLE; // [RL12]
                track_ff <= 1'b0;
                flush_ff <= 1'b1;
                if (shut_arm_ff) begin
                  ref_pwr_ff <= 1'b0; // [RL17]
                end
                // otherwise the reference is left running [RL15]
              end
            end
          end
          default: begin
            st_ff <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // sar: 14 result steps plus two sub-bit steps, paced by the conversion clock
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sr_ff <= SR_IDLE;
      div_ff <= 8'h00;
      bit_ff <= 4'h0;
      dac_ff <= {`ADCW_WORD_W{1'b0}};
      conv_pwr_ff <= 1'b0; // [RL13]
      busy_ff <= 1'b0;
    end else begin
      if (sr_ff == SR_RUN && !conv_tick) begin
        div_ff <= div_ff + 8'h01; // [RL24]
      end else begin
        div_ff <= 8'h00;
      end
      case (sr_ff)
        SR_IDLE: begin
          if (conv_start_ff) begin
            conv_pwr_ff <= 1'b1; // [RL14]
            busy_ff <= 1'b1;
            bit_ff <= `ADCW_SAR_TOP;
            dac_ff <= {1'b1, {(`ADCW_WORD_W-1){1'b0}}};
            sr_ff <= SR_RUN;
          end
        end
        SR_RUN: begin
          if (conv_tick) begin
            // code is plain unipolar binary, one step per trial [RL20]
            dac_ff[bit_ff] <= cmp_in;
            if (bit_ff == 4'h0) begin
              sr_ff <= SR_PUSH;
            end else begin
              dac_ff[bit_ff - 4'h1] <= 1'b1;
              bit_ff <= bit_ff - 4'h1;
            end
          end
        end
        SR_PUSH: begin
          // a full fifo stalls here rather than dropping a result
          if (fifo_in_ready) begin
            conv_pwr_ff <= 1'b0; // [RL14]
            busy_ff <= 1'b0;
            sr_ff <= SR_IDLE;
          end
        end
        default: begin
          sr_ff <= SR_IDLE;
          busy_ff <= 1'b0;
        end
      endcase
    end
  end

  adcw_fifo #(
    .W(`ADCW_WORD_W),
    .DEPTH(FIFO_DEPTH),
    .AW(`ADCW_FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .flush(flush_ff),
    .in_valid(sr_ff == SR_PUSH),
    .in_ready(fifo_in_ready),
    .in_data(dac_ff),
    .out_valid(fifo_out_valid),
    .out_ready(pop_ff),
    .out_data(fifo_out_data)
  );
endmodule // adcw_top

// File: common/adcw_map.vh
// constants of the two-wire converter slave
`ifndef ADCW_MAP_VH
`define ADCW_MAP_VH
`define ADCW_SYS_CLK_HZ 25000000
`define ADCW_CONV_CLK_HZ 4000000
`define ADCW_CONV_DIV (`ADCW_SYS_CLK_HZ / `ADCW_CONV_CLK_HZ)
`define ADCW_FS_MAX_KSPS_X10 190
`define ADCW_HS_MAX_KSPS_X10 586
`define ADCW_REF_SETTLE_MS 12
`define ADCW_ADDR_FIXED 3'h3
`define ADCW_HS_CODE 5'h01
`define ADCW_BYTE_BITS 4'h8
`define ADCW_TRACK_BIT 4'h7
`define ADCW_RES_W 14
`define ADCW_SUB_W 2
`define ADCW_WORD_W 16
`define ADCW_SAR_TOP 4'hf
`define ADCW_FIFO_DEPTH 8
`define ADCW_FIFO_AW 3
`endif

// File: verilog/adcw_fifo.v
// result fifo with registered read data
`timescale 1ns/10ps
module adcw_fifo #(
  parameter W = 16,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  input wire flush,
  // filling side
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  // draining side
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_ff;
  reg [AW-1:0] rd_ptr_ff;
  reg [AW:0] count_ff;
  reg out_valid_ff;
  reg [W-1:0] out_data_ff;
  wire push;
  wire load;
  localparam [AW:0] FULL_CNT = DEPTH[AW:0];

  assign in_ready = (count_ff != FULL_CNT);
  assign push = in_valid & in_ready;
  // refill the output register whenever a word is stored and the register is empty or being taken
  assign load = (count_ff != {(AW+1){1'b0}}) & (~out_valid_ff | out_ready);
  assign out_valid = out_valid_ff;
  assign out_data = out_data_ff;

  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
      out_valid_ff <= 1'b0;
      out_data_ff <= {W{1'b0}};
    end else if (flush) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
      out_valid_ff <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (load) begin
        out_data_ff <= mem[rd_ptr_ff];
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
        out_valid_ff <= 1'b1;
      end else if (out_ready) begin
        out_valid_ff <= 1'b0;
      end
      count_ff <= count_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
    end
  end
endmodule // adcw_fifo

// File: testbench/adcw_top_asserts.sv
// pin-level assertions of the two-wire converter slave
`timescale 1ns/10ps
module adcw_top_asserts #(
  parameter CONV_DIV = 6
) (
  // clock and reset
  input logic clk,
  input logic rst_n,
  // bus
  input logic scl_in,
  input logic sda_in,
  input logic scl_oe,
  input logic sda_oe,
  // strap and status
  input logic reference_adjust_pin,
  input logic track,
  input logic hs_mode,
  input logic conv_pwr,
  input logic ref_pwr,
  input logic conv_busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [9:0] hold_ff;
  // counts cycles of the current clock stretch
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) hold_ff <= 10'h000;
    else if (scl_oe) hold_ff <= hold_ff + 10'h001;
    else hold_ff <= 10'h000;
  end
  a_stretch_len: assert property (
    $fell(scl_oe) |-> hold_ff >= 16 * CONV_DIV) else $error("stretch too short");
  a_stretch_busy: assert property (
    conv_busy [*3] |-> scl_oe) else $error("scl free during conversion");
  a_busy_pwr: assert property (
    conv_busy && $past(conv_busy) |-> conv_pwr) else $error("converting unpowered");
  a_auto_down: assert property (
    $fell(conv_busy) |-> ##[0:2] !conv_pwr) else $error("no power-down");
  a_ext_ref: assert property (
    reference_adjust_pin [*5] |-> !ref_pwr) else $error("reference on in ext mode");
  a_hs_stop: assert property (
    $rose(sda_in) && scl_in |-> ##[1:8] !hs_mode) else $error("hs kept after stop");
  a_hs_nack: assert property (
    $rose(hs_mode) |-> !sda_oe && !scl_oe) else $error("hs entry not after nack");
  a_track_hold: assert property (
    $rose(conv_busy) |-> !track && $past(track, 2)) else $error("conversion without track");
  a_sda_scl_low: assert property (
    $changed(sda_oe) |-> !$past(scl_in)) else $error("sda moved with scl high");
  a_ref_wake: assert property (
    $rose(ref_pwr) |-> ##[0:2] scl_oe) else $error("reference woke off address");
  c_stretch: cover property ($fell(scl_oe));
  c_hs: cover property ($rose(hs_mode));
  c_ref_off: cover property ($fell(ref_pwr));
endmodule // adcw_top_asserts
bind adcw_top adcw_top_asserts #(.CONV_DIV(CONV_DIV)) u_adcw_top_asserts (
  .clk(clk), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in), .scl_oe(scl_oe),
  .sda_oe(sda_oe), .reference_adjust_pin(reference_adjust_pin), .track(track),
  .hs_mode(hs_mode), .conv_pwr(conv_pwr), .ref_pwr(ref_pwr), .conv_busy(conv_busy)
);

// File: testbench/adcw_master.sv
// two-wire bus master model, link clock of 320 ns
`timescale 1ns/10ps
module adcw_master (
  // pacing clock
  input wire clk,
  // resolved bus levels
  input wire scl_line,
  input wire sda_line,
  // open drain, 1 releases the line
  output reg m_scl,
  output reg m_sda
);
  initial begin
    m_scl = 1'b1;
    m_sda = 1'b1;
  end
  // one quarter of the link period
  task step(input logic s, input logic d);
    begin
      m_scl = s;
      m_sda = d;
      repeat (2) @(posedge clk);
      #1;
    end
  endtask
  task start;
    begin
      step(m_scl, 1'b1);
      step(1'b1, 1'b1);
      step(1'b1, 1'b0);
      step(1'b0, 1'b0);
    end
  endtask
  task stop;
    begin
      step(m_scl, m_sda);
      step(m_scl, 1'b0);
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
      step(1'b1, 1'b1);
    end
  endtask
  task bit_io(input logic b, output logic r);
    integer n;
    begin
      // data moves only mid-way through the low half, clear of both scl edges
      step(1'b0, m_sda);
      step(1'b0, b);
      step(1'b1, b);
      // the slave stretches the clock while it converts
      if (!scl_line) begin
        for (n = 0; n < 400 && !scl_line; n = n + 1) @(posedge clk);
        step(1'b1, b);
      end
      r = sda_line;
      step(1'b1, b);
      m_scl = 1'b0;
    end
  endtask
  task wr_byte(input logic [7:0] d, output logic ack);
    integer i;
    logic r;
    begin
      for (i = 7; i >= 0; i = i - 1) bit_io(d[i], r);
      bit_io(1'b1, ack);
    end
  endtask
  task rd_byte(input logic ack, output logic [7:0] d);
    integer i;
    logic r;
    begin
      for (i = 7; i >= 0; i = i - 1) bit_io(1'b1, d[i]);
      bit_io(ack, r);
    end
  endtask
endmodule // adcw_master

// File: testbench/adcw_top_tb.sv
// self-checking bench of the two-wire converter slave
`timescale 1ns/10ps
`include "adcw_map.vh"
module adcw_top_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ref_adj = 1'b0;
  logic [3:0] sel = 4'ha;
  logic [15:0] vin = 16'h9c35;
  logic [15:0] vt [0:2] = '{16'h0000, 16'hffff, 16'h2a5b};
  logic m_scl, m_sda, scl_oe, sda_oe, track, hs_mode, conv_pwr, ref_pwr, conv_busy, a;
  logic [`ADCW_WORD_W-1:0] dac_code;
  logic [15:0] w, w2;
  wire scl_in = m_scl & ~scl_oe;
  wire sda_in = m_sda & ~sda_oe;
  wire cmp_in = vin >= dac_code;
  wire [7:0] own1 = {3'h3, sel, 1'b1};
  wire [7:0] own0 = {3'h3, sel, 1'b0};
  integer err_count = 0;
  integer total_checks = 0;
  integer cyc = 0;
  always #20 clk = ~clk;
  adcw_top u_adcw_top (
    .clk(clk), .rst_n(rst_n), .scl_in(scl_in), .scl_out(), .scl_oe(scl_oe),
    .sda_in(sda_in), .sda_out(), .sda_oe(sda_oe), .address_select_pins(sel),
    .reference_adjust_pin(ref_adj), .cmp_in(cmp_in), .dac_code(dac_code),
    .track(track), .hs_mode(hs_mode), .conv_pwr(conv_pwr), .ref_pwr(ref_pwr),
    .conv_busy(conv_busy)
  );
  adcw_master u_adcw_master (
    .clk(clk), .scl_line(scl_in), .sda_line(sda_in), .m_scl(m_scl), .m_sda(m_sda)
  );
  task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("BAD %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task results;
    begin
      if (err_count == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  task wt(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task adr(input logic [7:0] b);
    begin
      u_adcw_master.start;
      u_adcw_master.wr_byte(b, a);
    end
  endtask
  task word(input logic [7:0] b);
    begin
      adr(b);
      u_adcw_master.rd_byte(1'b0, w[15:8]);
      u_adcw_master.rd_byte(1'b1, w[7:0]);
      u_adcw_master.stop;
    end
  endtask
  task t_reset;
    begin
      chk("hs", hs_mode, 1'b0);
      chk("conv", conv_pwr, 1'b0);
      chk("ref", ref_pwr, 1'b0);
    end
  endtask
  task t_read;
    integer i;
    begin
      for (i = 0; i < 3; i = i + 1) begin
        vin = vt[i];
        word(own1);
        chk("ack", a, 1'b0);
        chk("word", w, vt[i]);
        chk("conv", conv_pwr, 1'b0);
        chk("ref", ref_pwr, 1'b1);
      end
    end
  endtask
  task t_stream;
    begin
      vin = 16'h1234;
      adr(own1);
      u_adcw_master.rd_byte(1'b0, w[15:8]);
      // the first word is already latched for sending, so the input may move
      vin = 16'h4321;
      u_adcw_master.rd_byte(1'b0, w[7:0]);
      u_adcw_master.rd_byte(1'b0, w2[15:8]);
      u_adcw_master.rd_byte(1'b1, w2[7:0]);
      chk("sda free", sda_oe, 1'b0);
      wt(4);
      chk("scl free", scl_oe, 1'b0);
      u_adcw_master.stop;
      chk("first", w, 16'h1234);
      chk("second", w2, 16'h4321);
    end
  endtask
  task t_shut;
    begin
      word(own0);
      chk("ack", a, 1'b0);
      chk("word", w, vin);
      chk("ref", ref_pwr, 1'b0);
      adr(own1);
      wt(5);
      chk("ref", ref_pwr, 1'b1);
      chk("stretch", scl_oe, 1'b1);
      chk("conv", conv_pwr, 1'b1);
      // dummy word while the reference settles, value not judged
      u_adcw_master.rd_byte(1'b0, w[15:8]);
      u_adcw_master.rd_byte(1'b1, w[7:0]);
      u_adcw_master.stop;
    end
  endtask
  task t_foreign;
    begin
      adr({3'h3, ~sel, 1'b1});
      chk("ack", a, 1'b1);
      adr({3'h2, sel, 1'b1});
      chk("ack", a, 1'b1);
      chk("conv", conv_pwr, 1'b0);
      word(own1);
      chk("word", w, vin);
    end
  endtask
  task t_hs;
    integer i;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        adr(8'h08 | i[7:0]);
        wt(4);
        chk("nack", a, 1'b1);
        chk("hs", hs_mode, 1'b1);
        // repeated start with own address opens the fast transfer
        word(own1);
        chk("word", w, vin);
        wt(8);
        chk("hs", hs_mode, 1'b0);
      end
    end
  endtask
  task t_ext;
    begin
      ref_adj = 1'b1;
      wt(6);
      chk("ref", ref_pwr, 1'b0);
      word(own0);
      chk("ack", a, 1'b0);
      chk("word", w, vin);
      chk("ref", ref_pwr, 1'b0);
    end
  endtask
  // the run needs about 6400 cycles
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      results;
    end
  end
  initial begin
    wt(10);
    rst_n = 1'b1;
    wt(4);
    t_reset;
    t_read;
    t_stream;
    t_shut;
    t_foreign;
    t_hs;
    t_ext;
    results;
  end
endmodule // adcw_top_tb
